// [sst_pkg.sv]
/*
 * Package for the storage and source threshold register bank: register
 * offsets, field widths, reset codes and threshold scales in microvolts.
 * Assumes nothing of its surroundings.
 */
package sst_pkg;

    // ------------------------------------------------------------
    // Register offsets on the management port
    // ------------------------------------------------------------
    localparam logic [7:0] OVERDISCHARGE_OFS = 8'h05;
    localparam logic [7:0] CHARGE_READY_OFS = 8'h06;
    localparam logic [7:0] OVERCHARGE_OFS = 8'h07;
    localparam logic [7:0] BUCK_READY_OFS = 8'h0b;
    localparam logic [7:0] SOURCE_LOW_OFS = 8'h12;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // Field widths and reset codes
    // ------------------------------------------------------------
    localparam int SOURCE_LOW_W = 3;
    localparam int OVERDISCHARGE_W = 6;
    localparam int READY_W = 7;
    localparam logic [2:0] SOURCE_LOW_RST = 3'h0;
    localparam logic [2:0] SOURCE_LOW_FIRST_VALID = 3'h3;
    localparam logic [5:0] OVERDISCHARGE_RST = 6'h06;
    localparam logic [6:0] CHARGE_READY_RST = 7'h05;
    localparam logic [6:0] BUCK_READY_RST = 7'h05;
    localparam logic [6:0] OVERCHARGE_RST = 7'h3a;
    localparam logic [6:0] READY_MAX_CODE = 7'h63;

    // ------------------------------------------------------------
    // Voltage scales in microvolts, plus their bit width and the overcharge saturation code
    // ------------------------------------------------------------
    localparam int UV_W = 23;
    localparam int STEP_UV = 18750;
    localparam int OVERDISCHARGE_BASE_UV = 2400000;
    localparam int READY_BASE_UV = 2456000;
    localparam int OVERCHARGE_BASE_UV = 2700000;
    localparam logic [6:0] OVERCHARGE_SAT_CODE = 7'h66;
    localparam int OVERCHARGE_SAT_UV = 4594000;
    localparam int SOURCE_LOW_0_UV = 300000;
    localparam int SOURCE_LOW_1_UV = 360000;
    localparam int SOURCE_LOW_2_UV = 405000;
    localparam int SOURCE_LOW_3_UV = 510000;
    localparam int SOURCE_LOW_4_UV = 600000;

    // Regulation mode select values
    localparam logic MODE_CONST_VOLTAGE = 1'b0;
    localparam logic MODE_MAX_POWER = 1'b1;

endpackage

// [sst_lin_map.sv]
/*
 * Linear code to threshold mapper: base plus code times step, with an
 * optional saturation from a given code upward.
 * Assumes a static or registered code at its input.
 */
`timescale 1ns/100ps
`default_nettype none

module sst_lin_map #(
    parameter int CODE_W = 7,
    parameter int BASE_UV = 2456000,
    parameter int STEP = 18750,
    parameter int SAT_CODE = 128,
    parameter int SAT_UV = 0
) (
    input wire logic [CODE_W-1:0] code_in,
    output logic [sst_pkg::UV_W-1:0] level_out
);

    logic [31:0] lin_uv;

    assign lin_uv = 32'(BASE_UV) + 32'(code_in) * 32'(STEP);
    // Codes at or beyond the knee all give the ceiling value
    assign level_out = (32'(code_in) >= 32'(SAT_CODE)) ?
        sst_pkg::UV_W'(SAT_UV) : lin_uv[sst_pkg::UV_W-1:0];

endmodule

`default_nettype wire

// [sst_low_map.sv]
/*
 * Source-low code lookup: maps the 3-bit code to a threshold and flags
 * the reserved codes.
 * Assumes a registered code at its input.
 */
`timescale 1ns/100ps
`default_nettype none

module sst_low_map (
    input wire logic [2:0] code_in,
    output logic [sst_pkg::UV_W-1:0] level_out,
    output logic reserved_out
);

    always_comb begin
        reserved_out = 1'b0;
        unique case (code_in)
            3'h3: level_out = sst_pkg::UV_W'(sst_pkg::SOURCE_LOW_0_UV);
            3'h4: level_out = sst_pkg::UV_W'(sst_pkg::SOURCE_LOW_1_UV);
            3'h5: level_out = sst_pkg::UV_W'(sst_pkg::SOURCE_LOW_2_UV);
            3'h6: level_out = sst_pkg::UV_W'(sst_pkg::SOURCE_LOW_3_UV);
            3'h7: level_out = sst_pkg::UV_W'(sst_pkg::SOURCE_LOW_4_UV);
            default: begin
                // Reserved codes give no usable threshold
                level_out = '0;
                reserved_out = 1'b1;
            end
        endcase
    end

endmodule

`default_nettype wire

// [sst_regs.sv]
/*
 * Threshold register bank and decision logic for the source-low and
 * storage-element protection limits.
 * Assumes register accesses already decoded from the serial management
 * bus into a byte-wide address/data port, and measured voltages given in
 * microvolts, synchronous to clk_in.
 */
// How it works
// - Sleep below source-low; available above it
// - Source-low code maps to five voltages
// - Below overdischarge, stop discharging storage
// - Overdischarge is 2.400 V plus code steps
// - Supply state once charge-ready is reached
// - Charge-ready is 2.456 V plus code steps
// - Buck allowed at buck-ready without charger
// - Buck-ready uses the charge-ready scale
// - Stop charging at overcharge voltage
// - Overcharge linear, saturates from code 0x66
// - Mode bit decides if source-low must be valid
`timescale 1ns/100ps
`default_nettype none

module sst_regs (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic regulation_mode_select_in,
    input wire logic charger_5v_used_in,
    input wire logic [sst_pkg::UV_W-1:0] source_input_uv_in,
    input wire logic [sst_pkg::UV_W-1:0] max_power_voltage_uv_in,
    input wire logic [sst_pkg::UV_W-1:0] storage_uv_in,
    output logic [7:0] reg_rdata_out,
    output logic sleep_out,
    output logic source_available_out,
    output logic supply_out,
    output logic buck_allowed_out,
    output logic discharge_stop_out,
    output logic charge_stop_out,
    output logic source_low_invalid_out
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_b;
    logic rst_b;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_b <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_b <= rst_meta_b;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [2:0] source_low_code;
    logic [5:0] overdischarge_cfg;
    logic [6:0] charge_ready_cfg;
    logic [6:0] overcharge_cfg;
    logic [6:0] buck_ready_cfg;

    // Upper bits are never stored, so they cannot leak into a read
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            source_low_code <= sst_pkg::SOURCE_LOW_RST;
            overdischarge_cfg <= sst_pkg::OVERDISCHARGE_RST;
            charge_ready_cfg <= sst_pkg::CHARGE_READY_RST;
            overcharge_cfg <= sst_pkg::OVERCHARGE_RST;
            buck_ready_cfg <= sst_pkg::BUCK_READY_RST;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                sst_pkg::SOURCE_LOW_OFS: source_low_code <= reg_wdata_in[2:0];
                sst_pkg::OVERDISCHARGE_OFS: overdischarge_cfg <= reg_wdata_in[5:0];
                sst_pkg::CHARGE_READY_OFS: charge_ready_cfg <= reg_wdata_in[6:0];
                sst_pkg::OVERCHARGE_OFS: overcharge_cfg <= reg_wdata_in[6:0];
                sst_pkg::BUCK_READY_OFS: buck_ready_cfg <= reg_wdata_in[6:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        unique case (reg_addr_in)
            sst_pkg::SOURCE_LOW_OFS: next_rdata = {5'h00, source_low_code};
            sst_pkg::OVERDISCHARGE_OFS: next_rdata = {2'h0, overdischarge_cfg};
            sst_pkg::CHARGE_READY_OFS: next_rdata = {1'b0, charge_ready_cfg};
            sst_pkg::OVERCHARGE_OFS: next_rdata = {1'b0, overcharge_cfg};
            sst_pkg::BUCK_READY_OFS: next_rdata = {1'b0, buck_ready_cfg};
            default: next_rdata = sst_pkg::UNMAPPED_READ;
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Code to threshold mapping
    // ------------------------------------------------------------
    logic [sst_pkg::UV_W-1:0] source_low_voltage;
    logic [sst_pkg::UV_W-1:0] overdischarge_voltage;
    logic [sst_pkg::UV_W-1:0] charge_ready_voltage;
    logic [sst_pkg::UV_W-1:0] buck_ready_voltage;
    logic [sst_pkg::UV_W-1:0] overcharge_voltage;
    logic source_low_reserved;

    sst_low_map u_low_map (
        .code_in(source_low_code),
        .level_out(source_low_voltage),
        .reserved_out(source_low_reserved)
    );

    sst_lin_map #(
        .CODE_W(sst_pkg::OVERDISCHARGE_W),
        .BASE_UV(sst_pkg::OVERDISCHARGE_BASE_UV),
        .STEP(sst_pkg::STEP_UV),
        .SAT_CODE(64),
        .SAT_UV(0)
    ) u_overdischarge_map (
        .code_in(overdischarge_cfg),
        .level_out(overdischarge_voltage)
    );

    sst_lin_map #(
        .CODE_W(sst_pkg::READY_W),
        .BASE_UV(sst_pkg::READY_BASE_UV),
        .STEP(sst_pkg::STEP_UV),
        .SAT_CODE(128),
        .SAT_UV(0)
    ) u_charge_ready_map (
        .code_in(charge_ready_cfg),
        .level_out(charge_ready_voltage)
    );

    sst_lin_map #(
        .CODE_W(sst_pkg::READY_W),
        .BASE_UV(sst_pkg::READY_BASE_UV),
        .STEP(sst_pkg::STEP_UV),
        .SAT_CODE(128),
        .SAT_UV(0)
    ) u_buck_ready_map (
        .code_in(buck_ready_cfg),
        .level_out(buck_ready_voltage)
    );

    sst_lin_map #(
        .CODE_W(sst_pkg::READY_W),
        .BASE_UV(sst_pkg::OVERCHARGE_BASE_UV),
        .STEP(sst_pkg::STEP_UV),
        .SAT_CODE(int'(sst_pkg::OVERCHARGE_SAT_CODE)),
        .SAT_UV(sst_pkg::OVERCHARGE_SAT_UV)
    ) u_overcharge_map (
        .code_in(overcharge_cfg),
        .level_out(overcharge_voltage)
    );

    // ------------------------------------------------------------
    // Registered decisions
    // ------------------------------------------------------------
    // A reserved source-low code is left inert in either mode, so the
    // default never forces sleep; max-power mode only flags it.
    logic low_active;
    assign low_active = !source_low_reserved;

    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            sleep_out <= 1'b0;
            source_available_out <= 1'b0;
            source_low_invalid_out <= 1'b0;
        end else begin
            sleep_out <= low_active && (source_input_uv_in < source_low_voltage);
            source_available_out <= max_power_voltage_uv_in >
                (low_active ? source_low_voltage : '0);
            source_low_invalid_out <= source_low_reserved &&
                (regulation_mode_select_in == sst_pkg::MODE_MAX_POWER);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            supply_out <= 1'b0;
            buck_allowed_out <= 1'b0;
            discharge_stop_out <= 1'b1;
            charge_stop_out <= 1'b0;
        end else begin
            supply_out <= storage_uv_in >= charge_ready_voltage;
            buck_allowed_out <= !charger_5v_used_in &&
                (storage_uv_in >= buck_ready_voltage);
            discharge_stop_out <= storage_uv_in < overdischarge_voltage;
            charge_stop_out <= storage_uv_in >= overcharge_voltage;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence write_low_s(logic [7:0] d);
        reg_wr_in && reg_addr_in == sst_pkg::SOURCE_LOW_OFS && reg_wdata_in == d;
    endsequence

    sequence read_low_s;
        !reg_wr_in && reg_rd_in && reg_addr_in == sst_pkg::SOURCE_LOW_OFS;
    endsequence

    // Host leaves one quiet cycle between accesses
    sequence port_idle_s;
        !reg_wr_in && !reg_rd_in;
    endsequence

    sleep_cause_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        (!source_low_reserved && source_input_uv_in < source_low_voltage) |=> sleep_out)
        else $error("sleep not raised below source-low");

    low_map_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        source_low_code == 3'h3 |-> source_low_voltage == 23'd300000 && !source_low_reserved)
        else $error("source-low code 3 not 0.300 V");

    discharge_stop_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        storage_uv_in < overdischarge_voltage |=> discharge_stop_out)
        else $error("discharge not stopped below overdischarge");

    overdischarge_scale_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        overdischarge_cfg == 6'h06 |-> overdischarge_voltage == 23'd2512500)
        else $error("overdischarge scale wrong");

    supply_entry_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        $rose(supply_out) |-> $past(storage_uv_in >= charge_ready_voltage))
        else $error("supply without charge-ready");

    ready_scale_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        charge_ready_cfg == 7'h63 |-> charge_ready_voltage == 23'd4312250)
        else $error("charge-ready scale wrong");

    buck_gate_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        charger_5v_used_in |=> !buck_allowed_out)
        else $error("buck allowed while charger used");

    buck_scale_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        buck_ready_cfg == 7'h63 |-> buck_ready_voltage == 23'd4312250)
        else $error("buck-ready scale differs");

    charge_stop_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        (rst_b && storage_uv_in >= overcharge_voltage) |=> charge_stop_out)
        else $error("charging not stopped at overcharge");

    overcharge_sat_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        overcharge_cfg >= 7'h66 |-> overcharge_voltage == 23'd4594000)
        else $error("overcharge not saturated");

    mode_flag_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        (regulation_mode_select_in == 1'b0) |=> !source_low_invalid_out)
        else $error("invalid flag in constant-voltage mode");

    readback_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        write_low_s(8'hff) ##1 port_idle_s ##1 read_low_s |=> reg_rdata_out == 8'h07)
        else $error("reserved bits not read as zero");

    // Sampled rst_b keeps the first edge after release out of the antecedent
    avail_cause_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        (rst_b && !source_low_reserved && max_power_voltage_uv_in > source_low_voltage)
        |=> source_available_out)
        else $error("source not available above source-low");

    sleep_inert_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        source_low_reserved |=> !sleep_out)
        else $error("sleep forced by reserved source-low code");

    supply_level_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        storage_uv_in < charge_ready_voltage |=> !supply_out)
        else $error("supply below charge-ready");

    buck_allow_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        (rst_b && !charger_5v_used_in && storage_uv_in >= buck_ready_voltage)
        |=> buck_allowed_out)
        else $error("buck not allowed at buck-ready");

    overcharge_knee_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        overcharge_cfg == 7'h65 |-> overcharge_voltage == 23'd4593750)
        else $error("overcharge last linear step wrong");

    invalid_flag_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        (rst_b && source_low_reserved && regulation_mode_select_in)
        |=> source_low_invalid_out)
        else $error("reserved code not flagged in max-power mode");

    read_zero_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        reg_rd_in |=> !reg_rdata_out[7])
        else $error("reserved top bit read as one");

endmodule

`default_nettype wire

// [sst_host_model.sv]
/*
 * Host model for the threshold register port: single-byte writes and
 * reads, issued as the serial management host would after decoding.
 * Assumes the register port samples its strobes on the rising clk_in edge.
 */
`timescale 1ns/100ps
`default_nettype none

module sst_host_model (
    input wire logic clk_in,
    input wire logic [7:0] reg_rdata_in,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end

    // ------------------------------------------------------------
    // One access per call
    // ------------------------------------------------------------
    // Idle bus shows the inverse of the last value, so a stale byte never matches
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                          output logic [7:0] rdata);
        @(posedge clk_in);
        #1;
        reg_addr_out = addr;
        reg_wdata_out = data;
        reg_wr_out = wr;
        reg_rd_out = !wr;
        @(posedge clk_in);
        #1;
        rdata = reg_rdata_in;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = ~addr;
        reg_wdata_out = ~data;
    endtask
endmodule
`default_nettype wire

// [sst_regs_test.sv]
/*
 * Self-checking bench for the threshold register bank: register access,
 * threshold decisions at the boundaries, random traffic, mid-run reset.
 * Assumes the host model on the register port and a 40 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none

module sst_regs_test;
    localparam logic [7:0] OFS [5] = '{8'h05, 8'h06, 8'h07, 8'h0b, 8'h12};
    localparam logic [7:0] MSK [5] = '{8'h3f, 8'h7f, 8'h7f, 8'h7f, 8'h07};
    localparam logic [7:0] RSTV [5] = '{8'h06, 8'h05, 8'h3a, 8'h05, 8'h00};
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic mode = 1'b0;
    logic chg = 1'b0;
    logic [sst_pkg::UV_W-1:0] src_uv = '0;
    logic [sst_pkg::UV_W-1:0] mpp_uv = '0;
    logic [sst_pkg::UV_W-1:0] sto_uv = '0;
    logic [7:0] reg_addr, reg_wdata, rdata;
    logic reg_wr, reg_rd, slp, avl, sup, bck, dst, cst, inv;
    logic [7:0] sh [5];
    integer seed = 27;
    int err_total = 0;
    int check_count = 0;

    always #12.5 clk_in = ~clk_in;

    sst_host_model u_sst_host_model (.clk_in(clk_in), .reg_rdata_in(rdata),
        .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr),
        .reg_rd_out(reg_rd));

    sst_regs u_sst_regs (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .regulation_mode_select_in(mode), .charger_5v_used_in(chg),
        .source_input_uv_in(src_uv), .max_power_voltage_uv_in(mpp_uv),
        .storage_uv_in(sto_uv), .reg_rdata_out(rdata), .sleep_out(slp),
        .source_available_out(avl), .supply_out(sup), .buck_allowed_out(bck),
        .discharge_stop_out(dst), .charge_stop_out(cst), .source_low_invalid_out(inv));

    // ------------------------------------------------------------
    // Expected values
    // ------------------------------------------------------------
    function automatic int low_uv(logic [2:0] c);
        case (c)
            3'h3: return sst_pkg::SOURCE_LOW_0_UV;
            3'h4: return sst_pkg::SOURCE_LOW_1_UV;
            3'h5: return sst_pkg::SOURCE_LOW_2_UV;
            3'h6: return sst_pkg::SOURCE_LOW_3_UV;
            3'h7: return sst_pkg::SOURCE_LOW_4_UV;
            default: return 0;
        endcase
    endfunction

    function automatic int rdy_uv(logic [6:0] c);
        return sst_pkg::READY_BASE_UV + int'(c) * sst_pkg::STEP_UV;
    endfunction

    function automatic int ovc_uv(logic [6:0] c);
        if (c >= 7'h66)
            return sst_pkg::OVERCHARGE_SAT_UV;
        return sst_pkg::OVERCHARGE_BASE_UV + int'(c) * sst_pkg::STEP_UV;
    endfunction

    function automatic logic [7:0] exp_flags();
        logic res;
        int low, s;
        res = sh[4][2:0] < 3'h3;
        low = low_uv(sh[4][2:0]);
        s = int'(sto_uv);
        return {1'b0, !res && int'(src_uv) < low, res ? mpp_uv != 0 : int'(mpp_uv) > low,
            s >= rdy_uv(sh[1][6:0]), s >= rdy_uv(sh[3][6:0]) && !chg,
            s < sst_pkg::OVERDISCHARGE_BASE_UV + int'(sh[0][5:0]) * sst_pkg::STEP_UV,
            s >= ovc_uv(sh[2][6:0]), mode && res};
    endfunction

    function automatic int near(int thr);
        return thr + ($random(seed) % 3);
    endfunction

    // ------------------------------------------------------------
    // Drivers and comparisons
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_sst_host_model.access(1'b1, a, d, q);
        for (int i = 0; i < 5; i++)
            if (a == OFS[i])
                sh[i] = d & MSK[i];
    endtask

    task automatic rchk(input logic [7:0] a);
        logic [7:0] q, e;
        e = sst_pkg::UNMAPPED_READ;
        for (int i = 0; i < 5; i++)
            if (a == OFS[i])
                e = sh[i];
        u_sst_host_model.access(1'b0, a, 8'h00, q);
        chk(q, e, "read");
    endtask

    // Inputs are held two edges so registered decisions have settled
    task automatic drive(input int s, input int m, input int t, input logic md, input logic c);
        logic [7:0] seen;
        @(posedge clk_in);
        #1;
        src_uv = s[sst_pkg::UV_W-1:0];
        mpp_uv = m[sst_pkg::UV_W-1:0];
        sto_uv = t[sst_pkg::UV_W-1:0];
        mode = md;
        chg = c;
        repeat (2) @(posedge clk_in);
        #1;
        seen = {1'b0, slp, avl, sup, bck, dst, cst, inv};
        chk(seen, exp_flags(), "flags");
    endtask

    task automatic do_reset();
        rst_b_in = 1'b0;
        for (int i = 0; i < 5; i++)
            sh[i] = RSTV[i];
        repeat (8) @(posedge clk_in);
        #1;
        chk({1'b0, slp, avl, sup, bck, dst, cst, inv}, 8'h04, "reset flags");
        rst_b_in = 1'b1;
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < 5; i++)
            rchk(OFS[i]);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #(25 * 12000);
        err_total++;
        summarize();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        int idx;
        logic [6:0] oc [4];
        oc = '{7'h00, 7'h65, 7'h66, 7'h7f};
        do_reset();
        rchk(8'h00);
        rchk(8'h08);
        $display("test reset values done");
        for (int i = 0; i < 5; i++)
            wreg(OFS[i], 8'hff);
        rchk(OFS[4]);
        wreg(8'h13, 8'h5a);
        for (int i = 0; i < 5; i++)
            rchk(OFS[i]);
        $display("test reserved bits done");
        wreg(OFS[0], 8'h00);
        wreg(OFS[1], 8'h08);
        wreg(OFS[2], 8'h3a);
        wreg(OFS[4], 8'h03);
        drive(290000, 310000, 2600000, 1'b1, 1'b0);
        for (int md = 0; md < 2; md++)
            for (int c = 0; c < 8; c++) begin
                wreg(OFS[4], {5'h1f, c[2:0]});
                drive(low_uv(c[2:0]), low_uv(c[2:0]), 2500000, md[0], 1'b1);
                drive(low_uv(c[2:0]) - 1, low_uv(c[2:0]) + 1, 2500000, md[0], 1'b0);
            end
        $display("test source low done");
        for (int k = 0; k < 4; k++) begin
            wreg(OFS[2], {1'b0, oc[k]});
            drive(0, 0, ovc_uv(oc[k]) - 1, 1'b0, 1'b0);
            drive(0, 0, ovc_uv(oc[k]), 1'b0, 1'b0);
        end
        $display("test overcharge done");
        wreg(OFS[1], 8'h63);
        wreg(OFS[3], 8'h63);
        drive(0, 0, rdy_uv(7'h63) - 1, 1'b0, 1'b0);
        drive(0, 0, rdy_uv(7'h63), 1'b0, 1'b0);
        $display("test ready thresholds done");
        for (int n = 0; n < 150; n++) begin
            idx = $unsigned($random(seed)) % 6;
            wreg(idx == 5 ? 8'($random(seed)) : OFS[idx], 8'($random(seed)));
            case ($unsigned($random(seed)) % 4)
                0: idx = sst_pkg::OVERDISCHARGE_BASE_UV + int'(sh[0][5:0]) * sst_pkg::STEP_UV;
                1: idx = rdy_uv(sh[1][6:0]);
                2: idx = rdy_uv(sh[3][6:0]);
                default: idx = ovc_uv(sh[2][6:0]);
            endcase
            drive(near(low_uv(sh[4][2:0])), near(low_uv(sh[4][2:0])), near(idx),
                  1'($random(seed)), 1'($random(seed)));
            rchk(OFS[n % 5]);
        end
        $display("test random traffic done");
        do_reset();
        $display("test second reset done");
        summarize();
    end
endmodule
`default_nettype wire
